/* File: bench/adc_sequencing_control_props.sv */
// port checker of the converter control, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module adc_sequencing_control_props
(
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_low_power_entry,
    input wire logic       i_cmp_high,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq,
    input wire logic       o_conversion_done_irq,
    input wire logic [9:0] o_dac_trial,
    input wire logic [2:0] o_channel_select,
    input wire logic       o_analog_input_enable,
    input wire logic       o_analog_reference_on,
    input wire logic       o_sample_hold
);
    // ************************************************************
    // assertions, all in the one clock domain
    // ************************************************************
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    AST_DONE_PULSE: assert property (o_conversion_done_irq |=> !o_conversion_done_irq)
        else $error("done request longer than one cycle");
    AST_LP_REF_OFF: assert property (i_low_power_entry [*5] |-> !o_analog_reference_on)
        else $error("reference still connected in low power");
    AST_LP_HALT: assert property (i_low_power_entry [*5] |-> !o_sample_hold && !o_conversion_done_irq)
        else $error("converter running in low power");
    AST_LP_AIN_OFF: assert property (i_low_power_entry [*5] |-> !o_analog_input_enable)
        else $error("analog input enabled in low power");
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    AST_DISABLE_STOP: assert property (i_wr && i_addr == 4'h0 && i_wdata[6:5] == 2'b00 |-> ##2 !o_sample_hold)
        else $error("disable code did not stop the converter");
    AST_DISABLE_NO_STORE: assert property (i_wr && i_addr == 4'h0 && i_wdata[6:5] == 2'b00
        |-> ##2 !o_conversion_done_irq [*4])
        else $error("result stored after forced stop");
    AST_START_BUSY: assert property (i_wr && i_addr == 4'h0 && i_wdata[7] && i_wdata[6:5] != 2'b00 && !o_sample_hold
        && !i_low_power_entry |-> ##[1:3] o_sample_hold)
        else $error("start did not begin a conversion");
    AST_HOLD_MIN: assert property ($rose(o_sample_hold) |=> o_sample_hold [*8])
        else $error("conversion ended too early");
    AST_CFG_CHAN: assert property (i_wr && i_addr == 4'h0 && !i_low_power_entry
        |-> ##2 o_channel_select == $past(i_wdata[2:0], 2))
        else $error("channel select does not follow the write");
    AST_CFG_AIN: assert property (i_wr && i_addr == 4'h0 && !i_low_power_entry
        |-> ##2 o_analog_input_enable == $past(i_wdata[4], 2))
        else $error("analog input enable does not follow the write");
endmodule // adc_sequencing_control_props

bind adc_sequencing_control adc_sequencing_control_props props_u
(
    .i_clk                 (i_clk),
    .i_sys_rst             (i_sys_rst),
    .i_addr                (i_addr),
    .i_wdata               (i_wdata),
    .i_wr                  (i_wr),
    .i_rd                  (i_rd),
    .i_low_power_entry     (i_low_power_entry),
    .i_cmp_high            (i_cmp_high),
    .o_rdata               (o_rdata),
    .o_irq                 (o_irq),
    .o_conversion_done_irq (o_conversion_done_irq),
    .o_dac_trial           (o_dac_trial),
    .o_channel_select      (o_channel_select),
    .o_analog_input_enable (o_analog_input_enable),
    .o_analog_reference_on (o_analog_reference_on),
    .o_sample_hold         (o_sample_hold)
);
`default_nettype wire

/* File: bench/adc_sequencing_control_tb_top.sv */
// self-checking testbench of the converter control
`timescale 1ns/10ps
`default_nettype none
module adc_sequencing_control_tb_top;
    typedef struct packed { logic [2:0] chan; logic [2:0] tsel; logic mask; logic [9:0] res; } row_t;

    logic        i_clk     = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  i_addr    = 4'h0;
    logic [7:0]  i_wdata   = 8'h00;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic        i_lp      = 1'b0;
    logic [79:0] levels    = {10'h200, 10'h001, 10'h0f0, 10'h1a5, 10'h2aa, 10'h155, 10'h3ff, 10'h000};
    wire logic   cmp, irq, done, ref_on, sh, en;
    wire logic [7:0] rdata;
    wire logic [9:0] trial;
    wire logic [2:0] chan;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          done_cnt   = 0;
    int          n;
    row_t        rows [8] = '{'{3'h0, 3'h0, 1'b1, 10'h000}, '{3'h1, 3'h1, 1'b0, 10'h3ff},
                              '{3'h2, 3'h2, 1'b1, 10'h155}, '{3'h3, 3'h3, 1'b0, 10'h2aa},
                              '{3'h4, 3'h4, 1'b1, 10'h1a5}, '{3'h5, 3'h0, 1'b0, 10'h0f0},
                              '{3'h6, 3'h1, 1'b1, 10'h001}, '{3'h7, 3'h2, 1'b0, 10'h200}};

    always #10 i_clk = ~i_clk;

    adc_sequencing_control dut_u
    (
        .i_clk (i_clk), .i_sys_rst (i_sys_rst), .i_addr (i_addr), .i_wdata (i_wdata), .i_wr (i_wr),
        .i_rd (i_rd), .i_low_power_entry (i_lp), .i_cmp_high (cmp), .o_rdata (rdata), .o_irq (irq),
        .o_conversion_done_irq (done), .o_dac_trial (trial), .o_channel_select (chan),
        .o_analog_input_enable (en), .o_analog_reference_on (ref_on), .o_sample_hold (sh)
    );

    analog_source src_u
    (
        .i_levels (levels), .i_chan (chan), .i_enable (en), .i_trial (trial), .o_above (cmp)
    );

    // count stored results seen at the port
    always @(posedge i_clk)
    begin
        if (done === 1'b1)
            done_cnt++;
    end

    // ************************************************************
    // bus tasks and comparison
    // ************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 chk(name, exp, rdata);
    endtask

    task automatic wait_done(input int lim);
        int k;
        k = 0;
        while (done !== 1'b1 && k < lim)
        begin
            @(posedge i_clk);
            #1 k++;
        end
        chk("done pulse", 8'h01, {7'h00, done});
    endtask

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++)
            rd(a[3:0], 8'h00, "reset value");
        wr(4'ha, 8'hff);
        rd(4'ha, 8'h00, "unmapped");
        // single conversions on every channel and on time select codes 0 to 4
        foreach (rows[i])
        begin
            wr(4'h5, {7'h00, rows[i].mask});
            wr(4'h0, {4'h3, 1'b0, rows[i].chan});
            wr(4'h1, {5'h00, rows[i].tsel});
            wr(4'h0, {4'hb, 1'b0, rows[i].chan});
            rd(4'h0, {4'h3, 1'b0, rows[i].chan}, "start bit");
            wait_done(700);
            rd(4'h1, {5'h10, rows[i].tsel}, "end flag");
            chk("irq", {7'h00, rows[i].mask}, {7'h00, irq});
            rd(4'h2, rows[i].res[7:0], "result low");
            rd(4'h3, {6'h00, rows[i].res[9:8]}, "result high");
            rd(4'h1, {5'h00, rows[i].tsel}, "end flag cleared");
            rd(4'h4, 8'h01, "status");
            rd(4'h4, 8'h00, "status cleared");
            chk("irq cleared", 8'h00, {7'h00, irq});
        end
        // restart before the upper result is read
        wr(4'h0, 8'hb2);
        wait_done(300);
        wr(4'h0, 8'hb3);
        rd(4'h1, 8'h42, "restart flags");
        rd(4'h3, 8'h01, "old result high");
        wait_done(300);
        rd(4'h2, 8'haa, "new result low");
        // low-power entry in mid-conversion
        wr(4'h1, 8'h04);
        wr(4'h0, 8'hb1);
        repeat (20) @(posedge i_clk);
        chk("reference on", 8'h01, {7'h00, ref_on});
        n = done_cnt;
        i_lp <= 1'b1;
        repeat (10) @(posedge i_clk);
        rd(4'h0, 8'h01, "ctl1 low power");
        rd(4'h1, 8'h04, "ctl2 low power");
        rd(4'h2, 8'h00, "low power result");
        chk("reference", 8'h00, {7'h00, ref_on});
        @(posedge i_clk);
        i_lp <= 1'b0;
        repeat (700) @(posedge i_clk);
        chk("no resume", n[7:0], done_cnt[7:0]);
        chk("halted", 8'h00, {7'h00, sh});
        // repeat mode, then forced stop; the two restart results still sit in status
        rd(4'h4, 8'h01, "status before repeat");
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h75);
        wr(4'h0, 8'hf5);
        wait_done(100);
        repeat (3) @(posedge i_clk);
        chk("repeat restart", 8'h01, {7'h00, sh});
        rd(4'h4, 8'h01, "repeat status");
        wr(4'h1, 8'h03);
        rd(4'h1, 8'hc0, "time select held while busy");
        repeat (8) @(posedge i_clk);
        wr(4'h0, 8'h15);
        rd(4'h1, 8'h00, "stopped flags");
        rd(4'h2, 8'h00, "stopped low");
        rd(4'h3, 8'h00, "stopped high");
        repeat (60) @(posedge i_clk);
        rd(4'h4, 8'h00, "no store after stop");
        // completion between the low and high reads is dropped
        wr(4'h0, 8'h74);
        wr(4'h0, 8'hf4);
        wait_done(100);
        rd(4'h4, 8'h01, "first status");
        rd(4'h2, 8'ha5, "first low");
        @(posedge i_clk);
        levels[49:40] <= 10'h2c3;
        n = done_cnt;
        repeat (50) @(posedge i_clk);
        rd(4'h4, 8'h02, "dropped status");
        chk("dropped pulse", n[7:0], done_cnt[7:0]);
        rd(4'h3, 8'h01, "kept high");
        wait_done(100);
        rd(4'h2, 8'hc3, "next low");
        wr(4'h0, 8'h14);
        print_verdict();
    end

    // watchdog against a hang
    initial
    begin
        #(20 * 20000);
        num_errors++;
        print_verdict();
    end
endmodule // adc_sequencing_control_tb_top
`default_nettype wire

/* File: bench/analog_source.sv */
// analog input sources on the eight shared pins, seen through an ideal comparator
`timescale 1ns/10ps
`default_nettype none
module analog_source
(
    input  wire logic [79:0] i_levels,
    input  wire logic [2:0]  i_chan,
    input  wire logic        i_enable,
    input  wire logic [9:0]  i_trial,
    output logic             o_above
);
    logic [9:0] level;

    // pin level sits half a step above its code, so ties resolve upward; a disabled input reads ground
    always_comb
    begin
        level   = i_levels[i_chan*10 +: 10];       // other pins stay quiet
        o_above = i_enable && (level >= i_trial);
    end
endmodule // analog_source
`default_nettype wire

/* File: hw/adc_ctl_map.vh */
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTL_MAP_VH
`define ADC_CTL_MAP_VH

// register byte offsets on the plain register port
`define OFS_CONV_CONTROL_ONE  4'h0
`define OFS_CONV_CONTROL_TWO  4'h1
`define OFS_RESULT_LOW_BYTE   4'h2
`define OFS_RESULT_HIGH_BITS  4'h3
`define OFS_IRQ_STATUS        4'h4
`define OFS_IRQ_MASK          4'h5

// conv_control_one fields
`define BIT_START             7
`define BIT_AIN_ENABLE        4
`define MODE_HI               6
`define MODE_LO               5
`define CHAN_HI               2
`define CHAN_LO               0

// conv_control_two fields
`define BIT_END_FLAG          7
`define BIT_BUSY_FLAG         6
`define CKSEL_HI              2
`define CKSEL_LO              0

// operating mode codes
`define MODE_DISABLE          2'h0
`define MODE_SINGLE           2'h1
`define MODE_REPEAT           2'h3

// reset value of every register
`define REG_RESET             8'h00

// conversion length per time select code, in clock cycles
`define CONV_CYC_0            10'h027
`define CONV_CYC_1            10'h04e
`define CONV_CYC_2            10'h09c
`define CONV_CYC_3            10'h138
`define CONV_CYC_4            10'h270

`endif

/* File: hw/adc_sequencing_control.v */
// converter control: registers, start and stop sequencing, result handling, interrupt
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_map.vh"

module adc_sequencing_control
(
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire       i_low_power_entry,
    input  wire       i_cmp_high,
    output reg  [7:0] o_rdata,
    output reg        o_irq,
    output reg        o_conversion_done_irq,
    output reg  [9:0] o_dac_trial,
    output reg  [2:0] o_channel_select,
    output reg        o_analog_input_enable,
    output reg        o_analog_reference_on,
    output reg        o_sample_hold
);

    // ************************************************************
    // state and registers
    // ************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_STORE = 2'h2;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        conversion_start_bit;
    reg  [1:0] operating_mode_field;
    reg        analog_input_enable;
    reg  [2:0] channel_select;
    reg  [2:0] time_select;
    reg        conversion_end_flag;
    reg        converter_busy_flag;
    reg  [7:0] result_low_byte;
    reg  [1:0] result_high_bits;
    reg        low_read_pending;
    reg  [1:0] irq_status;
    reg  [1:0] irq_mask;
    reg        cmp_meta;
    reg        cmp_sync;
    reg        lp_meta;
    reg        lp_sync;
    reg  [1:0] step_div;

    wire       timer_run;
    wire       timer_done;
    wire [9:0] sar_trial;
    wire [9:0] sar_value;
    wire       wr_ctl1;
    wire       force_stop;
    wire       start_req;
    wire       conv_begin;
    wire       rd_high;
    wire       rd_low;
    wire       rd_status;
    wire       store_ok;
    wire       store_now;
    wire       step_tick;

    // ************************************************************
    // pin synchronisers
    // ************************************************************

    // comparator and low-power request come from outside this clock
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            lp_meta  <= 1'b0;
            lp_sync  <= 1'b0;
        end
        else
        begin
            cmp_meta <= i_cmp_high;
            cmp_sync <= cmp_meta;
            lp_meta  <= i_low_power_entry;
            lp_sync  <= lp_meta;
        end
    end

    // ************************************************************
    // access decode
    // ************************************************************
    assign wr_ctl1    = i_wr && (i_addr == `OFS_CONV_CONTROL_ONE);
    assign force_stop = wr_ctl1 && (i_wdata[`MODE_HI:`MODE_LO] == `MODE_DISABLE);
    assign rd_high    = i_rd && (i_addr == `OFS_RESULT_HIGH_BITS);
    assign rd_low     = i_rd && (i_addr == `OFS_RESULT_LOW_BYTE);
    assign rd_status  = i_rd && (i_addr == `OFS_IRQ_STATUS);
    // start only from an enabled mode and an idle converter
    assign start_req  = conversion_start_bit && (operating_mode_field != `MODE_DISABLE) && (state == ST_IDLE);
    // repeat mode chains the next conversion right after a store
    assign conv_begin = start_req || ((state == ST_STORE) && (operating_mode_field == `MODE_REPEAT));
    // a completion between the low and high reads is dropped
    assign store_ok   = !(low_read_pending && !rd_high);
    assign store_now  = (state == ST_STORE) && store_ok;

    // ************************************************************
    // conversion engine
    // ************************************************************

    // decision pace: trial flop, output flop and two comparator flops make the answer
    // four cycles late; at the shortest length the tenth step lands just before the store
    always @(posedge i_clk)
    begin
        if (i_sys_rst || conv_begin)
            step_div <= 2'h0;
        else
            step_div <= step_div + 2'h1;
    end

    // one decision enable every fourth cycle
    assign step_tick = (step_div == 2'h3);

    conv_timer u_timer
    (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_start    (conv_begin),
        .i_abort    (force_stop || lp_sync),
        .i_time_sel (time_select),
        .o_run      (timer_run),
        .o_done     (timer_done)
    );

    sar_core u_sar
    (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_start    (conv_begin),
        .i_abort    (force_stop || lp_sync),
        .i_step     (step_tick),
        .i_cmp_high (cmp_sync),
        .o_trial    (sar_trial),
        .o_value    (sar_value)
    );

    // next state of the sequencer
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:  if (start_req) next_state = ST_CONV;
            ST_CONV:  if (timer_done) next_state = ST_STORE;
            ST_STORE: next_state = (operating_mode_field == `MODE_REPEAT) ? ST_CONV : ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
        if (force_stop || lp_sync)
            next_state = ST_IDLE;
    end

    // ************************************************************
    // control, flags and results
    // ************************************************************

    // register updates; low-power entry and disable code clear as documented
    always @(posedge i_clk)
    begin
        if (i_sys_rst || lp_sync)
        begin
            state                <= ST_IDLE;
            conversion_start_bit <= 1'b0;
            operating_mode_field <= `MODE_DISABLE;
            analog_input_enable  <= 1'b0;
            conversion_end_flag  <= 1'b0;
            converter_busy_flag  <= 1'b0;
            result_low_byte      <= `REG_RESET;
            result_high_bits     <= 2'h0;
            low_read_pending     <= 1'b0;
            if (i_sys_rst)
            begin
                channel_select <= 3'h0;
                time_select    <= 3'h0;
            end
        end
        else
        begin
            state <= next_state;
            if (rd_low)
                low_read_pending <= 1'b1;
            else if (rd_high)
                low_read_pending <= 1'b0;
            if (wr_ctl1)
            begin
                conversion_start_bit <= i_wdata[`BIT_START];
                operating_mode_field <= i_wdata[`MODE_HI:`MODE_LO];
                analog_input_enable  <= i_wdata[`BIT_AIN_ENABLE];
                channel_select       <= i_wdata[`CHAN_HI:`CHAN_LO];
            end
            else if (conv_begin)
                conversion_start_bit <= 1'b0;
            if (i_wr && (i_addr == `OFS_CONV_CONTROL_TWO) && !converter_busy_flag)
                time_select <= i_wdata[`CKSEL_HI:`CKSEL_LO];
            if (force_stop)
            begin
                conversion_end_flag <= 1'b0;
                converter_busy_flag <= 1'b0;
                result_low_byte     <= `REG_RESET;
                result_high_bits    <= 2'h0;
            end
            else
            begin
                if (conv_begin)
                    converter_busy_flag <= 1'b1;
                else if ((state == ST_STORE) && (operating_mode_field != `MODE_REPEAT))
                    converter_busy_flag <= 1'b0;
                if (store_now)
                begin
                    result_low_byte     <= sar_value[7:0];
                    result_high_bits    <= sar_value[9:8];
                    conversion_end_flag <= 1'b1;
                end
                else if (rd_high || start_req)
                    conversion_end_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // interrupt status, mask and outputs
    // ************************************************************

    // sticky status: bit0 done, bit1 dropped result; set wins over read clear
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            irq_status            <= 2'h0;
            irq_mask              <= 2'h0;
            o_conversion_done_irq <= 1'b0;
            o_irq                 <= 1'b0;
        end
        else
        begin
            o_conversion_done_irq <= store_now && !force_stop && !lp_sync;
            irq_status <= (rd_status ? 2'h0 : irq_status)
                        | {(state == ST_STORE) && !store_ok, store_now && !force_stop && !lp_sync};
            if (i_wr && (i_addr == `OFS_IRQ_MASK))
                irq_mask <= i_wdata[1:0];
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // read data one cycle after the read strobe, unmapped reads as zero
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_rdata <= `REG_RESET;
        else if (i_rd)
        begin
            case (i_addr)
                `OFS_CONV_CONTROL_ONE: o_rdata <= {conversion_start_bit, operating_mode_field,
                                                   analog_input_enable, 1'b0, channel_select};
                `OFS_CONV_CONTROL_TWO: o_rdata <= {conversion_end_flag, converter_busy_flag, 3'h0, time_select};
                `OFS_RESULT_LOW_BYTE:  o_rdata <= result_low_byte;
                `OFS_RESULT_HIGH_BITS: o_rdata <= {6'h00, result_high_bits};
                `OFS_IRQ_STATUS:       o_rdata <= {6'h00, irq_status};
                `OFS_IRQ_MASK:         o_rdata <= {6'h00, irq_mask};
                default:               o_rdata <= `REG_RESET;
            endcase
        end
        else
            o_rdata <= `REG_RESET;
    end

    // analog side drives; reference drops with low-power entry
    always @(posedge i_clk)
    begin
        if (i_sys_rst || lp_sync)
        begin
            o_dac_trial           <= 10'h000;
            o_channel_select      <= 3'h0;
            o_analog_input_enable <= 1'b0;
            o_analog_reference_on <= 1'b0;
            o_sample_hold         <= 1'b0;
        end
        else
        begin
            o_dac_trial           <= sar_trial;
            o_channel_select      <= channel_select;
            o_analog_input_enable <= analog_input_enable;
            o_analog_reference_on <= analog_input_enable && (operating_mode_field != `MODE_DISABLE);
            o_sample_hold         <= timer_run;
        end
    end

endmodule // adc_sequencing_control
`default_nettype wire

/* File: hw/conv_timer.v */
// conversion length counter: counts a selected number of cycles and pulses on completion
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctl_map.vh"

module conv_timer
(
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_start,
    input  wire       i_abort,
    input  wire [2:0] i_time_sel,
    output reg        o_run,
    output reg        o_done
);

    reg  [9:0] count;

    // length table for the time select codes, reserved codes fall back to the longest
    function [9:0] conv_len;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    conv_len = `CONV_CYC_0;
                3'h1:    conv_len = `CONV_CYC_1;
                3'h2:    conv_len = `CONV_CYC_2;
                3'h3:    conv_len = `CONV_CYC_3;
                default: conv_len = `CONV_CYC_4;
            endcase
        end
    endfunction

    // count down while running; abort wins over everything
    always @(posedge i_clk)
    begin
        o_done <= 1'b0;
        if (i_sys_rst || i_abort)
        begin
            o_run <= 1'b0;
            count <= 10'h000;
        end
        else if (i_start)
        begin
            o_run <= 1'b1;
            count <= conv_len(i_time_sel) - 10'h001;
        end
        else if (o_run)
        begin
            if (count == 10'h000)
            begin
                o_run  <= 1'b0;
                o_done <= 1'b1;
            end
            else
                count <= count - 10'h001;
        end
    end

endmodule // conv_timer
`default_nettype wire

/* File: hw/sar_core.v */
// successive approximation engine: one bit decided per step against the comparator
`timescale 1ns/10ps
`default_nettype none

module sar_core
(
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_start,
    input  wire       i_abort,
    input  wire       i_step,
    input  wire       i_cmp_high,
    output reg  [9:0] o_trial,
    output reg  [9:0] o_value
);

    reg  [9:0] bitpos;

    // keep the trial bit when the input is above the trial level, then try the next lower bit
    always @(posedge i_clk)
    begin
        if (i_sys_rst || i_abort)
        begin
            o_trial <= 10'h000;
            o_value <= 10'h000;
            bitpos  <= 10'h000;
        end
        else if (i_start)
        begin
            o_trial <= 10'h200;
            o_value <= 10'h000;
            bitpos  <= 10'h200;
        end
        else if (i_step && (bitpos != 10'h000))
        begin
            if (i_cmp_high)
                o_value <= o_value | bitpos;
            bitpos  <= bitpos >> 1;
            o_trial <= (i_cmp_high ? (o_value | bitpos) : o_value) | (bitpos >> 1);
        end
    end

endmodule // sar_core
`default_nettype wire
